//--- design/ppa_pkg.sv
package ppa_pkg;

  // effective address layout
  localparam int          EA_W        = 16;
  localparam int          EA_TOP      = 15;
  localparam int          PAGE_W      = 10;
  localparam int          PS_ADDR_W   = 25;

  // read page register values with boundary meaning
  localparam logic [9:0]  PG_ZERO     = 10'h000;
  localparam logic [9:0]  PG_FIRST    = 10'h001;
  localparam logic [9:0]  PG_LSW_LAST = 10'h2ff;
  localparam logic [9:0]  PG_LSW_FRST = 10'h200;
  localparam logic [9:0]  PG_MSB_FRST = 10'h300;
  localparam logic [9:0]  PG_MSB_LAST = 10'h3ff;
  localparam logic [9:0]  PG_ONE      = 10'h001;
  localparam logic [9:0]  PG_RESET    = 10'h001;

  // addressing modes presented by the address generator
  typedef enum logic [2:0] {
    PPA_MODE_DIRECT,
    PPA_MODE_PRE_INC,
    PPA_MODE_POST_INC,
    PPA_MODE_PRE_DEC,
    PPA_MODE_POST_DEC,
    PPA_MODE_REG_OFFSET,
    PPA_MODE_MODULO,
    PPA_MODE_BIT_REV
  } ppa_mode_t;

  // outcome of the page check
  typedef enum logic [2:0] {
    PPA_ACT_NONE,
    PPA_ACT_INC,
    PPA_ACT_DEC,
    PPA_ACT_WRAP,
    PPA_ACT_BASE
  } ppa_act_t;

endpackage : ppa_pkg

//--- design/ppa_page_decide.sv
module ppa_page_decide
  import ppa_pkg::*;
(
  // request
  input  wire logic [9:0] i_page,
  input  wire ppa_mode_t  i_mode,
  input  wire logic       i_old_top,
  input  wire logic       i_carry,
  input  wire logic       i_borrow,
  // decision
  output ppa_act_t        o_act
);

  ////////////////////////////////////////////////////////////////////////////
  logic crossed;
  logic linear;

  always_comb begin
    crossed = i_old_top && (i_carry || i_borrow);
    linear  = (i_mode == PPA_MODE_PRE_INC) || (i_mode == PPA_MODE_POST_INC) ||
              (i_mode == PPA_MODE_PRE_DEC) || (i_mode == PPA_MODE_POST_DEC);
    o_act   = PPA_ACT_NONE;
    if (crossed && i_page != PG_ZERO) begin
      if (!linear) begin
        o_act = PPA_ACT_WRAP;
      end else if (i_carry) begin
        if (i_page == PG_MSB_LAST) begin
          o_act = PPA_ACT_BASE;
        end else begin
          o_act = PPA_ACT_INC;
        end
      end else begin
        if (i_page == PG_FIRST || i_page == PG_LSW_FRST) begin
          o_act = PPA_ACT_BASE;
        end else begin
          o_act = PPA_ACT_DEC;
        end
      end
    end
  end

endmodule : ppa_page_decide

//--- design/ppa_page_adjust.sv
module ppa_page_adjust
  import ppa_pkg::*;
(
  // clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  // request from address generator
  input  wire logic                 i_req,
  input  wire logic                 i_write,
  input  wire ppa_mode_t            i_mode,
  input  wire logic [EA_W-1:0]      i_ea_old,
  input  wire logic [EA_W-1:0]      i_ea_raw,
  input  wire logic                 i_carry,
  input  wire logic                 i_borrow,
  // software load of the read page register
  input  wire logic                 i_page_we,
  input  wire logic [PAGE_W-1:0]    i_page_wdata,
  // results
  output logic                      o_valid,
  output logic [EA_W-1:0]           o_ea,
  output logic [PAGE_W-1:0]         o_read_page_register,
  output logic                      o_ps_access,
  output logic [PS_ADDR_W-1:0]      o_ps_addr,
  output logic                      o_addr_error,
  output logic                      o_write_refused
);

  ////////////////////////////////////////////////////////////////////////////
  ppa_act_t               act;
  logic [PAGE_W-1:0]      page;
  logic [PAGE_W-1:0]      next_page;
  logic [EA_W-1:0]        next_ea;
  logic                   next_valid;
  logic                   next_ps_access;
  logic [PS_ADDR_W-1:0]   next_ps_addr;
  logic                   next_addr_error;
  logic                   next_write_refused;
  logic                   new_top;
  logic                   hits_window;
  logic                   hits_zero;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one step of the read page register, up or down
  function automatic logic [PAGE_W-1:0] step_page(
    input logic [PAGE_W-1:0] pg,
    input logic              up
  );
    logic [PAGE_W-1:0] stepped;
    if (up) begin
      stepped = pg + PG_ONE;
    end else begin
      stepped = pg - PG_ONE;
    end
    return stepped;
  endfunction : step_page

  // bit 15 of the address once the page action is applied
  function automatic logic corrected_top(
    input ppa_act_t a,
    input logic     raw_top
  );
    logic top;
    case (a)
      PPA_ACT_INC: begin
        top = 1'h1;
      end
      PPA_ACT_DEC: begin
        top = 1'h1;
      end
      PPA_ACT_WRAP: begin
        top = 1'h1;
      end
      PPA_ACT_BASE: begin
        top = 1'h0;
      end
      PPA_ACT_NONE: begin
        top = raw_top;
      end
      default: begin
        top = raw_top;
      end
    endcase
    return top;
  endfunction : corrected_top

  // true when the page selects nothing in program space
  function automatic logic page_is_zero(
    input logic [PAGE_W-1:0] pg
  );
    return pg == PG_ZERO;
  endfunction : page_is_zero

  ////////////////////////////////////////////////////////////////////////////
  // page decision

  // page zero on a crossing gets no action; bit 15 stays as the adder left it, so the trap check below does not fire
  ppa_page_decide u_decide (
    .i_page    (page),
    .i_mode    (i_mode),
    .i_old_top (i_ea_old[EA_TOP]),
    .i_carry   (i_carry),
    .i_borrow  (i_borrow),
    .o_act     (act)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read page register

  // a step from a crossing wins over a load in the same cycle
  always_comb begin
    next_page = page;
    if (i_page_we) begin
      next_page = i_page_wdata;
    end
    if (i_req) begin
      case (act)
        PPA_ACT_INC: begin
          next_page = step_page(page, 1'h1);
        end
        PPA_ACT_DEC: begin
          next_page = step_page(page, 1'h0);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      page <= PG_RESET;
    end else begin
      page <= next_page;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // corrected address

  // the adder drops bit 15 on a crossing; the action decides its final value
  // and the address is held between requests
  always_comb begin
    next_valid = i_req;
    next_ea    = o_ea;
    new_top    = 1'h0;
    if (i_req) begin
      next_ea = i_ea_raw;
      if (act != PPA_ACT_NONE) begin
        next_ea[EA_TOP] = 1'h0;
      end
      new_top         = corrected_top(act, next_ea[EA_TOP]);
      next_ea[EA_TOP] = new_top;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'h0;
      o_ea    <= '0;
    end else begin
      o_valid <= next_valid;
      o_ea    <= next_ea;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // where the access lands

  // an address in the window with page zero is a trap, never a fetch
  always_comb begin
    hits_window = new_top && !page_is_zero(next_page);
    hits_zero   = new_top && page_is_zero(next_page);
  end

  always_comb begin
    next_ps_access = 1'h0;
    next_ps_addr   = o_ps_addr;
    if (hits_window && !i_write) begin
      next_ps_access = 1'h1;
      next_ps_addr   = {next_page, next_ea[EA_TOP-1:0]};
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ps_access <= 1'h0;
      o_ps_addr   <= '0;
    end else begin
      o_ps_access <= next_ps_access;
      o_ps_addr   <= next_ps_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refused accesses

  always_comb begin
    next_addr_error    = hits_zero;
    next_write_refused = hits_window && i_write;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_addr_error    <= 1'h0;
      o_write_refused <= 1'h0;
    end else begin
      o_addr_error    <= next_addr_error;
      o_write_refused <= next_write_refused;
    end
  end

  assign o_read_page_register = page;

endmodule : ppa_page_adjust

//--- verification/ppa_agen.sv
module ppa_agen
  import ppa_pkg::*;
(
  // pointer before the step and the adder's answer
  input  wire logic [EA_W-1:0] i_old,
  input  wire logic            i_up,
  output logic [EA_W-1:0]      o_raw,
  output logic                 o_cy,
  output logic                 o_bw
);
  timeunit 1ns;
  timeprecision 1ns;
  // word steps only, never a large offset
  assign o_raw = i_old + (i_up ? 16'h0002 : 16'hfffe);
  assign o_cy  = i_old[15] & i_up & ~o_raw[15];
  assign o_bw  = i_old[15] & ~i_up & ~o_raw[15];
endmodule : ppa_agen

//--- verification/ppa_page_adjust_chk.sv
module ppa_chk
  import ppa_pkg::*;
(
  // watched ports
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_req,
  input wire logic        i_write,
  input wire ppa_mode_t   i_mode,
  input wire logic [15:0] i_ea_old,
  input wire logic        i_carry,
  input wire logic        i_borrow,
  input wire logic        i_page_we,
  input wire logic [15:0] o_ea,
  input wire logic [9:0]  o_read_page_register,
  input wire logic        o_ps_access,
  input wire logic [24:0] o_ps_addr,
  input wire logic        o_addr_error,
  input wire logic        o_write_refused
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [9:0] pg = o_read_page_register;
  wire cr  = i_req & i_ea_old[15] & (i_carry | i_borrow);
  wire hit = i_req & i_ea_old[15] & ~i_carry & ~i_borrow;
  wire ind = i_mode != PPA_MODE_DIRECT && i_mode < PPA_MODE_REG_OFFSET;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  a_ovf_next: assert property (cr && ind && i_carry &&
    pg == PG_LSW_LAST |=> pg == PG_MSB_FRST && o_ea[15]) else $error("ovf");
  a_udf_back: assert property (cr && ind && !i_carry &&
    pg == PG_MSB_FRST |=> pg == PG_LSW_LAST && o_ea[15]) else $error("udf");
  a_wrap_keep: assert property (cr && !ind && !i_page_we &&
    pg != PG_ZERO |=> $stable(pg) && o_ea[15]) else $error("wrap");
  a_base_exit: assert property (cr && ind && i_carry && !i_page_we &&
    pg == PG_MSB_LAST |=> !o_ea[15] && $stable(pg)) else $error("base");
  a_trap_zero: assert property (hit && pg == PG_ZERO |=>
    o_addr_error && !o_ps_access) else $error("trap");
  a_write_refuse: assert property (hit && i_write && pg != PG_ZERO |=>
    o_write_refused && !o_ps_access) else $error("refuse");
  a_ps_map: assert property (o_ps_access |->
    o_ps_addr == {pg, o_ea[14:0]}) else $error("map");
  a_no_cross: assert property (i_req && !i_ea_old[15] && !i_page_we |=>
    $stable(pg)) else $error("outside");
  c_cross: cover property (cr && ind);
  c_trap: cover property (o_addr_error);
  c_refuse: cover property (o_write_refused);
endmodule : ppa_chk
bind ppa_page_adjust ppa_chk u_chk (.*);

//--- verification/ppa_page_adjust_test.sv
module ppa_page_adjust_test
  import ppa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst = 1'h1, req = 1'h0, wr = 1'h0, up = 1'h0, pwe = 1'h0;
  logic [9:0] pwd = 10'h000, pg;
  logic [15:0] old = 16'h0000, raw, ea;
  logic cy, bw, vld, psa, aer, wrf;
  ppa_mode_t mode = PPA_MODE_DIRECT;
  int n_fail = 0, comparisons = 0, cyc = 0;
  ppa_agen MODEL (.i_old(old), .i_up(up), .o_raw(raw), .o_cy(cy), .o_bw(bw));
  ppa_page_adjust DUT (
    .i_clk_sys(clk), .i_rst(rst), .i_req(req), .i_write(wr), .i_mode(mode),
    .i_ea_old(old), .i_ea_raw(raw), .i_carry(cy), .i_borrow(bw),
    .i_page_we(pwe), .i_page_wdata(pwd), .o_valid(vld), .o_ea(ea),
    .o_read_page_register(pg), .o_ps_access(psa), .o_ps_addr(),
    .o_addr_error(aer), .o_write_refused(wrf));
  task automatic cmp(input logic [29:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp
  // load page, issue one access, check {page, ea, valid, ps, trap, refuse}
  task automatic acc(input logic [9:0] p, input ppa_mode_t m,
                     input logic [15:0] o, input logic w, input logic [29:0] e);
    @(posedge clk);
    pwe <= 1'h1;
    pwd <= p;
    @(posedge clk);
    pwe <= 1'h0;
    req <= 1'h1;
    mode <= m;
    old <= o;
    wr <= w;
    up <= !(m inside {PPA_MODE_PRE_DEC, PPA_MODE_POST_DEC});
    @(posedge clk);
    req <= 1'h0;
    #1;
    cmp(e, {pg, ea, vld, psa, aer, wrf});
  endtask : acc
  task automatic s_cross;
    acc(10'h2ff, PPA_MODE_PRE_INC, 16'hfffe, 1'h0, 30'h3008000c);
    acc(10'h300, PPA_MODE_POST_DEC, 16'h8000, 1'h0, 30'h2fffffec);
    acc(10'h3ff, PPA_MODE_POST_INC, 16'hfffe, 1'h0, 30'h3ff00008);
    acc(10'h200, PPA_MODE_PRE_DEC, 16'h8000, 1'h0, 30'h2007ffe8);
    acc(10'h001, PPA_MODE_POST_DEC, 16'h8000, 1'h0, 30'h0017ffe8);
  endtask : s_cross
  task automatic s_wrap;
    for (int k = 5; k < 8; k++) begin
      acc(10'h005, ppa_mode_t'(k), 16'hfffe, 1'h0, 30'h0058000c);
    end
    acc(10'h005, PPA_MODE_PRE_INC, 16'h7ffe, 1'h0, 30'h0058000c);
    acc(10'h005, PPA_MODE_DIRECT, 16'hfffe, 1'h0, 30'h0058000c);
  endtask : s_wrap
  task automatic s_trap;
    acc(10'h000, PPA_MODE_PRE_INC, 16'h8010, 1'h0, 30'h0008012a);
    acc(10'h005, PPA_MODE_PRE_INC, 16'h8010, 1'h1, 30'h00580129);
  endtask : s_trap
  // mid-run reset, then a read at the first edge after release
  task automatic s_reset;
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    req <= 1'h1;
    mode <= PPA_MODE_PRE_INC;
    old <= 16'h8010;
    wr <= 1'h0;
    up <= 1'h1;
    #1;
    cmp(30'h00100000, {pg, ea, vld, psa, aer, wrf});
    @(posedge clk);
    req <= 1'h0;
    #1;
    cmp(30'h0018012c, {pg, ea, vld, psa, aer, wrf});
  endtask : s_reset
  task automatic conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    s_cross();
    s_wrap();
    s_trap();
    s_reset();
    conclude();
  end
endmodule : ppa_page_adjust_test
